// File: design/fdm_pkg.sv
// Package for the fan drive mode controller: constants, modes, carriers
package fdm_pkg;
    localparam int unsigned CLK_HZ = 125_000_000;
    localparam int unsigned WAKE_MAX_MS = 500;
    localparam int unsigned QUIET_MS = 600;
    localparam int unsigned RETRY_STEP_S = 5;
    localparam int unsigned RETRY_CAP_S = 25;
    localparam int unsigned NOTIFY_MIN_S = 30;
    localparam int unsigned FREQ_MIN_HZ = 100;
    localparam int unsigned FREQ_MAX_HZ = 50000;
    // Cycle counts (longest command period rounds up, other times round down)
    localparam longint unsigned WAKE_CYC = longint'(WAKE_MAX_MS) * CLK_HZ / 1000;
    localparam longint unsigned QUIET_CYC = longint'(QUIET_MS) * CLK_HZ / 1000;
    localparam longint unsigned STEP_CYC = longint'(RETRY_STEP_S) * CLK_HZ;
    localparam longint unsigned NOTIFY_CYC = longint'(NOTIFY_MIN_S) * CLK_HZ;
    localparam longint unsigned PERIOD_MAX_CYC = (CLK_HZ + FREQ_MIN_HZ - 1) / FREQ_MIN_HZ;
    localparam int unsigned RETRY_STEPS = RETRY_CAP_S / RETRY_STEP_S;
    localparam int unsigned DUTY_W = 8;
    localparam logic [7:0] DUTY_FULL = 8'hff;
    localparam logic [7:0] DUTY_ZERO = 8'h00;

    typedef enum logic [3:0] {
        FDM_QUIET = 4'h1,
        FDM_ACTIVE = 4'h2,
        FDM_RUN = 4'h4,
        FDM_FAIL = 4'h8
    } fdm_mode_t;

    // Fault sources from the power stage and sensors
    typedef struct packed {
        logic blocked;
        logic hot_stop;
        logic overload;
        logic undervolt;
        logic overvolt;
        logic overcurrent;
        logic internal;
    } fdm_fault_t;

    typedef struct packed {
        logic valid;
        logic [7:0] duty;
    } fdm_duty_t;
endpackage

// File: design/fdm_duty_meter.sv
// Duty cycle meter for the speed/wake command
`timescale 1ns/1ps
module fdm_duty_meter #(
    parameter int unsigned PERIOD_MAX = 1250000
) (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic clk_en,
    input wire logic speed_wake_command,
    output fdm_pkg::fdm_duty_t duty_o
);
    localparam int CW = $clog2(PERIOD_MAX + 1);
    initial begin
        if (PERIOD_MAX < 2) $error("PERIOD_MAX too small");
    end
    logic [CW-1:0] per_ff, high_ff;
    logic in_d_ff;
    fdm_pkg::fdm_duty_t duty_ff;
    wire rise = speed_wake_command & ~in_d_ff;
    wire stuck = per_ff == CW'(PERIOD_MAX);
    // Ratio of high time to period, scaled to full byte
    wire [CW+7:0] scaled = {high_ff, 8'h00} - {8'h00, high_ff};
    wire [CW+7:0] ratio = scaled / {8'h00, (per_ff == '0) ? CW'(1) : per_ff};
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            per_ff <= '0;
            high_ff <= '0;
            in_d_ff <= 1'b0;
            duty_ff <= '0;
        end else if (clk_en) begin
            in_d_ff <= speed_wake_command;
            if (rise) begin
                // Rising cycle opens the new period and is itself high
                per_ff <= CW'(1);
                high_ff <= CW'(1);
                duty_ff.valid <= 1'b1;
                duty_ff.duty <= ratio[7:0];
            end else if (stuck) begin
                per_ff <= '0;
                high_ff <= '0;
                duty_ff.valid <= 1'b1;
                // Continuous level gives 0 or full duty
                duty_ff.duty <= speed_wake_command ? fdm_pkg::DUTY_FULL
                                                   : fdm_pkg::DUTY_ZERO;
            end else begin
                per_ff <= per_ff + CW'(1);
                high_ff <= high_ff + CW'(speed_wake_command);
            end
        end
    end
    assign duty_o = duty_ff;
endmodule // fdm_duty_meter

// File: design/fdm_mode_ctrl.sv
// Fan drive mode controller: modes, failure handling and fault flag
`timescale 1ns/1ps
// Summary of operation
// - Only two one-way signals: command in from host, fault flag out.
// - Drive raises fault flag high when dominant; host pulls it low.
// - Command at activation threshold wakes drive within 500 ms.
// - Command accepted at 100 Hz to 50 kHz, duty zero to full.
// - Four modes: quiescent, active, run, failure, chosen by duty and faults.
// - Zero duty below threshold longer than 600 ms gives quiescent mode.
// - Run only on valid duty requesting rotation; otherwise zero speed.
// - Any of seven faults enters failure mode and stops the motor; the code ignores faults in quiescent mode.
// - Excess current lowers speed; unreachable speed flags overload.
// - Blocked rotor retry wait 5 s, plus 5 s each failure, capped 25 s.
// - Overheat either derates speed or stops the motor.
// - Fault flag high only in failure mode, low otherwise.
// - Fault flag never before 30 s after the failure began.
// - No fault flag for undervoltage or overvoltage stops.
// - With a run request, leave failure mode once the fault clears.
module fdm_mode_ctrl #(
    parameter longint unsigned WAKE_CYC = fdm_pkg::WAKE_CYC,
    parameter longint unsigned QUIET_CYC = fdm_pkg::QUIET_CYC,
    parameter longint unsigned STEP_CYC = fdm_pkg::STEP_CYC,
    parameter longint unsigned NOTIFY_CYC = fdm_pkg::NOTIFY_CYC,
    parameter int unsigned PERIOD_MAX = 32'(fdm_pkg::PERIOD_MAX_CYC),
    parameter logic [7:0] RUN_MIN_DUTY = 8'h1a
) (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic clk_en,
    input wire logic speed_wake_command,
    input wire logic activation_threshold,
    input wire fdm_pkg::fdm_fault_t fault_in,
    input wire logic hot_derate,
    input wire logic current_excess,
    input wire logic start_ok,
    output logic fault_flag_output,
    output logic motor_enable,
    output logic [7:0] speed_request,
    output fdm_pkg::fdm_mode_t mode
);
    localparam int TW = 40;
    initial begin
        if (QUIET_CYC < 2 || STEP_CYC < 2 || NOTIFY_CYC < 2 || WAKE_CYC < 1)
            $error("timing counts too small");
        // Longest retry wait and notice delay must fit the timers
        if (STEP_CYC * fdm_pkg::RETRY_STEPS >= (64'h1 << TW) || NOTIFY_CYC >= (64'h1 << TW)
            || QUIET_CYC >= (64'h1 << TW))
            $error("timing counts too large for timers");
        if (RUN_MIN_DUTY == fdm_pkg::DUTY_ZERO)
            $error("run threshold must lie above zero duty");
    end

    // Duty is refreshed once per command period
    fdm_pkg::fdm_duty_t duty;
    fdm_duty_meter #(.PERIOD_MAX(PERIOD_MAX)) u_meter (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .clk_en(clk_en),
        .speed_wake_command(speed_wake_command),
        .duty_o(duty)
    );

    fdm_pkg::fdm_mode_t mode_ff, nxt_mode;
    logic [TW-1:0] quiet_ff, notify_ff, retry_ff;
    logic [2:0] steps_ff;
    logic [7:0] speed_ff;
    logic flag_ff;

    function automatic logic [TW-1:0] wait_of(input logic [2:0] n);
        wait_of = TW'(STEP_CYC) * TW'(n);
    endfunction

    wire run_req = duty.valid && duty.duty >= RUN_MIN_DUTY;
    wire any_fault = |fault_in;
    wire notifiable = any_fault & ~fault_in.undervolt & ~fault_in.overvolt;
    wire quiet_due = quiet_ff >= TW'(QUIET_CYC);
    wire idle_low = !activation_threshold && !speed_wake_command;
    wire retry_due = retry_ff >= wait_of(steps_ff);
    wire notify_due = notify_ff >= TW'(NOTIFY_CYC);

    always_comb begin
        nxt_mode = mode_ff;
        case (mode_ff)
            fdm_pkg::FDM_QUIET:
                if (activation_threshold) nxt_mode = fdm_pkg::FDM_ACTIVE;
            fdm_pkg::FDM_ACTIVE:
                if (any_fault) nxt_mode = fdm_pkg::FDM_FAIL;
                else if (quiet_due) nxt_mode = fdm_pkg::FDM_QUIET;
                else if (run_req) nxt_mode = fdm_pkg::FDM_RUN;
            fdm_pkg::FDM_RUN:
                if (any_fault) nxt_mode = fdm_pkg::FDM_FAIL;
                else if (!run_req) nxt_mode = fdm_pkg::FDM_ACTIVE;
            fdm_pkg::FDM_FAIL:
                // Leaves to run or active once all faults clear; with a fault still present, leaves only to quiescent on quiet timeout
                if (!any_fault && run_req) nxt_mode = fdm_pkg::FDM_RUN;
                else if (!any_fault) nxt_mode = fdm_pkg::FDM_ACTIVE;
                else if (quiet_due) nxt_mode = fdm_pkg::FDM_QUIET;
            default: nxt_mode = fdm_pkg::FDM_QUIET;
        endcase
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            mode_ff <= fdm_pkg::FDM_QUIET;
            quiet_ff <= '0;
            notify_ff <= '0;
            retry_ff <= '0;
            steps_ff <= 3'h1;
            flag_ff <= 1'b0;
        end else if (clk_en) begin
            mode_ff <= nxt_mode;
            quiet_ff <= idle_low ? (quiet_due ? quiet_ff : quiet_ff + TW'(1)) : '0;
            notify_ff <= (notifiable && mode_ff == fdm_pkg::FDM_FAIL)
                ? (notify_due ? notify_ff : notify_ff + TW'(1)) : '0;
            flag_ff <= nxt_mode == fdm_pkg::FDM_FAIL && notifiable && notify_due;
            if (mode_ff == fdm_pkg::FDM_FAIL && fault_in.blocked && run_req) begin
                if (retry_due) begin
                    retry_ff <= '0;
                    // Failed attempt lengthens the next wait up to the cap
                    if (!start_ok && steps_ff < 3'(fdm_pkg::RETRY_STEPS))
                        steps_ff <= steps_ff + 3'h1;
                end else begin
                    retry_ff <= retry_ff + TW'(1);
                end
            end else if (!fault_in.blocked) begin
                retry_ff <= '0;
                steps_ff <= 3'h1;
            end
        end
    end

    // Speed: derate on overheat or excess current, zero unless running
    wire [7:0] half = {1'b0, duty.duty[7:1]};
    wire derate = hot_derate | current_excess;
    wire attempt = mode_ff == fdm_pkg::FDM_FAIL && fault_in.blocked && run_req && retry_due;
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            speed_ff <= 8'h00;
        end else if (clk_en) begin
            if (mode_ff == fdm_pkg::FDM_RUN)
                speed_ff <= derate ? half : duty.duty;
            else
                speed_ff <= 8'h00;
        end
    end

    assign fault_flag_output = flag_ff;
    assign speed_request = speed_ff;
    assign motor_enable = (mode_ff == fdm_pkg::FDM_RUN) || attempt;
    assign mode = mode_ff;

    AST_WAKE: assert property (@(posedge clk_sys) disable iff (!nrst)
        clk_en && mode_ff == fdm_pkg::FDM_QUIET && activation_threshold
        |=> mode_ff != fdm_pkg::FDM_QUIET)
        else $error("no wake after activation");
    AST_FLAG_ONLY_FAIL: assert property (@(posedge clk_sys) disable iff (!nrst)
        fault_flag_output |-> mode_ff == fdm_pkg::FDM_FAIL)
        else $error("flag outside failure mode");
    AST_NOTIFY_DELAY: assert property (@(posedge clk_sys) disable iff (!nrst)
        fault_flag_output |-> notify_due)
        else $error("flag before minimum delay");
    AST_VOLT_SILENT: assert property (@(posedge clk_sys) disable iff (!nrst)
        $rose(fault_flag_output) |-> $past(notifiable))
        else $error("flag for supply fault");
    AST_STOP_ON_FAULT: assert property (@(posedge clk_sys) disable iff (!nrst)
        clk_en && any_fault && mode_ff == fdm_pkg::FDM_RUN
        |=> mode_ff == fdm_pkg::FDM_FAIL && (!motor_enable || attempt))
        else $error("motor runs in failure");
    AST_ZERO_IDLE: assert property (@(posedge clk_sys) disable iff (!nrst)
        mode_ff != fdm_pkg::FDM_RUN |-> ##1 (speed_request == 8'h00 || !$past(clk_en)))
        else $error("speed outside run");
    AST_QUIET_ENTRY: assert property (@(posedge clk_sys) disable iff (!nrst)
        $changed(mode_ff) && mode_ff == fdm_pkg::FDM_QUIET |-> $past(quiet_due))
        else $error("early quiescent entry");
    AST_RECOVER: assert property (@(posedge clk_sys) disable iff (!nrst)
        clk_en && mode_ff == fdm_pkg::FDM_FAIL && !any_fault && run_req
        |=> mode_ff == fdm_pkg::FDM_RUN)
        else $error("no recovery");
    AST_RETRY_CAP: assert property (@(posedge clk_sys) disable iff (!nrst)
        steps_ff >= 3'h1 && steps_ff <= 3'(fdm_pkg::RETRY_STEPS))
        else $error("retry wait out of range");

    // Mode, flag, speed and retry checks
    AST_ONE_HOT: assert property (@(posedge clk_sys) disable iff (!nrst)
        $onehot(mode_ff))
        else $error("mode not one-hot");
    AST_FAULT_ENTRY: assert property (@(posedge clk_sys) disable iff (!nrst)
        clk_en && any_fault && (mode_ff == fdm_pkg::FDM_ACTIVE || mode_ff == fdm_pkg::FDM_RUN)
        |=> mode_ff == fdm_pkg::FDM_FAIL)
        else $error("fault did not enter failure mode");
    AST_NO_RUN_LOW: assert property (@(posedge clk_sys) disable iff (!nrst)
        clk_en && !run_req |=> mode_ff != fdm_pkg::FDM_RUN)
        else $error("run without valid request");
    AST_FLAG_CLEAR: assert property (@(posedge clk_sys) disable iff (!nrst)
        clk_en && mode_ff == fdm_pkg::FDM_FAIL && !any_fault
        |=> !fault_flag_output)
        else $error("flag kept after failure cleared");
    AST_SPEED_RUN: assert property (@(posedge clk_sys) disable iff (!nrst)
        clk_en && mode_ff == fdm_pkg::FDM_RUN && !derate
        |=> speed_request == $past(duty.duty))
        else $error("run speed does not follow duty");
    AST_DERATE: assert property (@(posedge clk_sys) disable iff (!nrst)
        clk_en && mode_ff == fdm_pkg::FDM_RUN && derate && duty.duty != fdm_pkg::DUTY_ZERO
        |=> speed_request < $past(duty.duty))
        else $error("speed not lowered on derate");
    AST_RETRY_STEP: assert property (@(posedge clk_sys) disable iff (!nrst)
        clk_en && attempt && !start_ok && steps_ff < 3'(fdm_pkg::RETRY_STEPS)
        |=> steps_ff == $past(steps_ff) + 3'h1)
        else $error("retry wait not lengthened");
    AST_RETRY_HOLD: assert property (@(posedge clk_sys) disable iff (!nrst)
        clk_en && attempt && steps_ff == 3'(fdm_pkg::RETRY_STEPS)
        |=> steps_ff == 3'(fdm_pkg::RETRY_STEPS))
        else $error("retry wait left the cap");

    // Main scenarios reached
    COV_RUN: cover property (@(posedge clk_sys) mode_ff == fdm_pkg::FDM_RUN);
    COV_FLAG: cover property (@(posedge clk_sys) $rose(fault_flag_output));
    COV_QUIET: cover property (@(posedge clk_sys)
        $past(mode_ff) == fdm_pkg::FDM_ACTIVE && mode_ff == fdm_pkg::FDM_QUIET);
    COV_CAP: cover property (@(posedge clk_sys) steps_ff == 3'(fdm_pkg::RETRY_STEPS));
    COV_RETRY: cover property (@(posedge clk_sys) attempt);
endmodule // fdm_mode_ctrl

// File: testbench/fdm_host_model.sv
// Host control unit model driving the speed/wake command as PWM
`timescale 1ns/1ps
module fdm_host_model (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic [15:0] period,
    input wire logic [15:0] high,
    output logic speed_wake_command
);
    logic [15:0] cnt;
    // Host only pushes high; idle low stands for the drive's pull-down
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            cnt <= 16'h0000;
            speed_wake_command <= 1'b0;
        end else begin
            cnt <= (cnt + 16'h0001 >= period) ? 16'h0000 : cnt + 16'h0001;
            speed_wake_command <= (cnt < high);
        end
    end
endmodule // fdm_host_model

// File: testbench/tb.sv
// Self-checking bench for the fan drive mode controller
`timescale 1ns/1ps
module tb;
    localparam int NOTIFY = 100;
    logic clk_sys, nrst, clk_en, act, hot, cur, start_ok, cmd, flag, men;
    logic [15:0] period, high;
    logic [7:0] spd;
    fdm_pkg::fdm_fault_t flt;
    fdm_pkg::fdm_mode_t mode;
    int err_total, n_checks, p, h, e, w;
    int dq[$];
    fdm_host_model host (.clk_sys(clk_sys), .nrst(nrst), .period(period), .high(high),
        .speed_wake_command(cmd));
    fdm_mode_ctrl #(.QUIET_CYC(50), .STEP_CYC(20), .NOTIFY_CYC(NOTIFY), .PERIOD_MAX(64)) dut (
        .clk_sys(clk_sys), .nrst(nrst), .clk_en(clk_en), .speed_wake_command(cmd),
        .activation_threshold(act), .fault_in(flt), .hot_derate(hot), .current_excess(cur),
        .start_ok(start_ok), .fault_flag_output(flag), .motor_enable(men),
        .speed_request(spd), .mode(mode));
    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end
    task automatic results();
        if (err_total == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [7:0] ex, input logic [7:0] got);
        n_checks++;
        if (got !== ex) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", what, ex, got);
        end
    endtask
    // Speed scaling is the designer's; allow a few counts of rounding
    task automatic near(input string what, input int ex, input logic [7:0] got);
        n_checks++;
        if ($isunknown(got) || int'(got) > ex + 3 || int'(got) + 3 < ex) begin
            err_total++;
            $display("mismatch %s expected %0d seen %h", what, ex, got);
        end
    endtask
    task automatic wait_mode(input fdm_pkg::fdm_mode_t m, input int maxc);
        for (int i = 0; i < maxc && mode !== m; i++) @(negedge clk_sys);
        chk("mode", 8'(m), 8'(mode));
        if (mode !== m) results();
    endtask
    initial begin
        err_total = 0;
        n_checks = 0;
        {clk_en, act, hot, cur, start_ok, nrst} = 6'h20;
        flt = '0;
        period = 16'h0028;
        high = 16'h0000;
        void'($urandom(75976));
        repeat (4) @(posedge clk_sys);
        nrst <= 1'b1;
        @(negedge clk_sys);
        chk("mode", 8'(fdm_pkg::FDM_QUIET), 8'(mode));
        chk("flag", 8'h00, 8'(flag));
        @(posedge clk_sys);
        act <= 1'b1;
        clk_en <= 1'b0;
        repeat (5) @(negedge clk_sys);
        chk("frozen mode", 8'(fdm_pkg::FDM_QUIET), 8'(mode));
        @(posedge clk_sys);
        clk_en <= 1'b1;
        wait_mode(fdm_pkg::FDM_ACTIVE, 3);
        @(posedge clk_sys);
        high <= 16'h0002;
        repeat (200) @(negedge clk_sys);
        chk("low duty", 8'(fdm_pkg::FDM_ACTIVE), 8'(mode));
        repeat (3) begin
            p = 20 + $urandom_range(40);
            h = p / 4 + $urandom_range(p / 2);
            dq.push_back(h * 255 / p);
            @(posedge clk_sys);
            period <= 16'(p);
            high <= 16'(h);
            wait_mode(fdm_pkg::FDM_RUN, 300);
            repeat (200) @(negedge clk_sys);
            e = dq.pop_front();
            near("speed", e, spd);
            chk("motor_en", 8'h01, 8'(men));
        end
        @(posedge clk_sys);
        hot <= 1'b1;
        repeat (5) @(negedge clk_sys);
        near("derated", e / 2, spd);
        @(posedge clk_sys);
        hot <= 1'b0;
        cur <= 1'b1;
        repeat (5) @(negedge clk_sys);
        near("limited", e / 2, spd);
        @(posedge clk_sys);
        cur <= 1'b0;
        for (int i = 0; i < 6; i++) begin
            @(posedge clk_sys);
            flt <= 7'(1 << i);
            wait_mode(fdm_pkg::FDM_FAIL, 3);
            chk("motor_en", 8'h00, 8'(men));
            repeat (NOTIFY - 5) @(negedge clk_sys);
            chk("early flag", 8'h00, 8'(flag));
            repeat (10) @(negedge clk_sys);
            chk("flag", (i == 2 || i == 3) ? 8'h00 : 8'h01, 8'(flag));
            @(posedge clk_sys);
            flt <= '0;
            wait_mode(fdm_pkg::FDM_RUN, 3);
            @(negedge clk_sys);
            chk("flag clear", 8'h00, 8'(flag));
        end
        @(posedge clk_sys);
        flt <= 7'h40;
        wait_mode(fdm_pkg::FDM_FAIL, 3);
        for (int k = 1; k <= 6; k++) begin
            w = 0;
            while (men !== 1'b1 && w < 200) begin
                @(negedge clk_sys);
                w++;
            end
            near("retry gap", 20 * (k > 5 ? 5 : k), 8'(w));
            if (w >= 200) results();
            @(negedge clk_sys);
        end
        @(posedge clk_sys);
        flt <= '0;
        high <= 16'h0000;
        act <= 1'b0;
        repeat (40) @(negedge clk_sys);
        chk("early quiet", 8'h00, 8'(mode === fdm_pkg::FDM_QUIET));
        wait_mode(fdm_pkg::FDM_QUIET, 40);
        results();
    end
endmodule // tb
